/* dv/cfg_handshake_bench.sv */
// Self-checking bench for the configuration handshake block.
// Assumes the host model resolves the open-drain lines.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.svh"
module cfg_handshake_bench import cfg_loader_pkg::*;;
	localparam logic [1:0] OK = `CFG_RESP_OKAY;
	localparam logic [1:0] SE = `CFG_RESP_SLVERR;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, cfg_begin_n, cfg_status_low_n_in, cfg_status_low_n_oe;
	logic cfg_finished_wired_in, cfg_finished_wired_oe, user_startup_clock, internal_osc_clock_out;
	logic last_byte_read, frame_error, supply_fault, load_enable, user_mode, irq, osc_prev;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	cfg_state_t  cfg_phase;
	int          err_total = 0, total_checks = 0, span;
	logic [33:0] exp_q[$];
	cfg_handshake #(.POWERUP_CYCLES(24'h32)) u_cfg_handshake (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cfg_begin_n, .cfg_status_low_n_in, .cfg_status_low_n_oe, .cfg_finished_wired_in,
		.cfg_finished_wired_oe, .user_startup_clock, .internal_osc_clock_out, .last_byte_read, .frame_error,
		.supply_fault, .load_enable, .user_mode, .cfg_phase, .irq);
	cfg_host_model u_cfg_host_model (.aclk, .cfg_status_low_n_oe, .cfg_finished_wired_oe, .cfg_status_low_n_in,
		.cfg_finished_wired_in, .cfg_begin_n, .last_byte_read, .frame_error, .user_startup_clock, .supply_fault);
	initial begin
		forever #5 aclk = ~aclk;
	end
	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic expire(input string nm);
		err_total++;
		$display("[ERR] %s exp done seen timeout", nm);
		conclude();
	endtask
	// ------------------------------------------------------------
	// Bus and phase helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 100);
		s_axi_bready <= 1'h0;
		if (!s_axi_bvalid)
			expire("bvalid");
		check("bresp", 34'(s_axi_bresp), 34'(e));
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		exp_q.push_back(e);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 100);
		s_axi_rready <= 1'h0;
		if (!s_axi_rvalid)
			expire("rvalid");
	endtask
	// Read answers matched against the oldest note
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	end
	task automatic wait_phase(input cfg_state_t p, input int lim);
		span = 0;
		#1;
		while (cfg_phase !== p && span < lim) begin
			@(posedge aclk);
			#1;
			span++;
		end
		if (cfg_phase !== p)
			expire(p.name());
	endtask
	task automatic load_done(input logic hold);
		u_cfg_host_model.drive(1'h1, 1'h0, hold);
		u_cfg_host_model.pulse(1'h0);
		wait_phase(CFG_DONE_WAIT, 3);
		check("done_oe", 34'(cfg_finished_wired_oe), 34'h0);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(19291));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		#1;
		check("status_oe", 34'(cfg_status_low_n_oe), 34'h1);
		wait_phase(CFG_IDLE, 60);
		check("status_oe", 34'(cfg_status_low_n_oe), 34'h0);
		rd(`CFG_REG_CTRL, {OK, 32'h0});
		rd(`CFG_REG_IRQ_MASK, {OK, 32'h0});
		rd(8'h10, {SE, 32'h0});
		wr(8'h20, 32'h7, SE);
		wr(`CFG_REG_IRQ_MASK, 32'h7, OK);
		u_cfg_host_model.drive(1'h1, 1'h0, 1'h0);
		wait_phase(CFG_LOAD, 3);
		repeat ($urandom_range(30, 1)) @(posedge aclk);
		#1;
		check("load_en", {cfg_finished_wired_oe, load_enable}, 34'h3);
		check("status_line", 34'(cfg_status_low_n_in), 34'h1);
		load_done(1'h0);
		wait_phase(CFG_INIT, 3);
		wait_phase(CFG_USER, 300);
		check("init_len", 34'(span >= 220 && span <= 255), 34'h1);
		repeat (2) @(posedge aclk);
		#1;
		check("user_irq", {user_mode, irq}, 34'h3);
		osc_prev = internal_osc_clock_out;
		repeat (25) @(posedge aclk);
		#1;
		check("osc_out", 34'(internal_osc_clock_out), 34'(!osc_prev));
		rd(`CFG_REG_STATE, {OK, 32'he7});
		rd(`CFG_REG_IRQ_STAT, {OK, 32'h2});
		wr(`CFG_REG_IRQ_STAT, 32'h2, OK);
		repeat (2) @(posedge aclk);
		check("irq_clr", 34'(irq), 34'h0);
		u_cfg_host_model.drive(1'h1, 1'h1, 1'h0);
		wait_phase(CFG_ERROR, 3);
		u_cfg_host_model.drive(1'h1, 1'h0, 1'h0);
		repeat (40) @(posedge aclk);
		check("fault_hold", {cfg_status_low_n_oe, irq, user_mode}, 34'h6);
		u_cfg_host_model.restart();
		wait_phase(CFG_LOAD, 10);
		load_done(1'h1);
		wait_phase(CFG_ERROR, 300);
		check("tmo_len", 34'(span >= 220 && span <= 255), 34'h1);
		check("tmo_status", {cfg_status_low_n_oe, cfg_status_low_n_in}, 34'h2);
		wr(`CFG_REG_CTRL, 32'h6, OK);
		u_cfg_host_model.restart();
		wait_phase(CFG_LOAD, 10);
		load_done(1'h1);
		repeat (300) @(posedge aclk);
		check("no_tmo", 34'(cfg_phase), 34'(CFG_DONE_WAIT));
		u_cfg_host_model.drive(1'h1, 1'h0, 1'h0);
		wait_phase(CFG_INIT, 3);
		repeat (300) @(posedge aclk);
		u_cfg_host_model.uclocks(9);
		check("uclk_wait", 34'(cfg_phase), 34'(CFG_INIT));
		u_cfg_host_model.uclocks(1);
		wait_phase(CFG_USER, 10);
		wr(`CFG_REG_CTRL, 32'h1, OK);
		wr(`CFG_REG_IRQ_STAT, 32'h7, OK);
		u_cfg_host_model.restart();
		wait_phase(CFG_LOAD, 10);
		u_cfg_host_model.pulse(1'h1);
		wait_phase(CFG_RESTART, 5);
		check("rst_status", 34'(cfg_status_low_n_oe), 34'h1);
		wait_phase(CFG_LOAD, 220);
		check("rst_len", 34'(span >= 195 && span <= 205 && !cfg_status_low_n_oe), 34'h1);
		rd(`CFG_REG_IRQ_STAT, {OK, 32'h1});
		u_cfg_host_model.drive(1'h0, 1'h0, 1'h0);
		wait_phase(CFG_IDLE, 3);
		check("idle_out", {cfg_finished_wired_oe, load_enable}, 34'h0);
		conclude();
	end
	initial begin
		repeat (90000) @(posedge aclk);
		expire("run");
	end
endmodule
`default_nettype wire

/* dv/cfg_host_model.sv */
// Far-side controller model: start input, data pulses, user clock.
// Assumes the board pulls both open-drain lines up.
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
	input  wire logic aclk,                  // System clock
	input  wire logic cfg_status_low_n_oe,   // Device pulls status low
	input  wire logic cfg_finished_wired_oe, // Device pulls done low
	output logic      cfg_status_low_n_in,   // Resolved status line
	output logic      cfg_finished_wired_in, // Resolved done line
	output logic      cfg_begin_n,           // Start input
	output logic      last_byte_read,        // Final byte pulse
	output logic      frame_error,           // Data error pulse
	output logic      user_startup_clock,    // User start-up clock
	output logic      supply_fault           // Supply fault level
);
	logic hold_done = 1'h0;
	assign cfg_status_low_n_in   = !cfg_status_low_n_oe;
	assign cfg_finished_wired_in = !(cfg_finished_wired_oe || hold_done);
	initial begin
		cfg_begin_n        = 1'h0;
		last_byte_read     = 1'h0;
		frame_error        = 1'h0;
		user_startup_clock = 1'h0;
		supply_fault       = 1'h0;
	end
	// optional external hold of the done line
	task automatic drive(input logic b, input logic f, input logic h);
		@(posedge aclk);
		cfg_begin_n  <= b;
		supply_fault <= f;
		hold_done    <= h;
	endtask
	// serial bytes go LSB first upstream; only the end pulse comes here
	task automatic pulse(input logic err);
		@(posedge aclk);
		last_byte_read <= !err;
		frame_error    <= err;
		@(posedge aclk);
		last_byte_read <= 1'h0;
		frame_error    <= 1'h0;
	endtask
	task automatic restart();
		@(posedge aclk);
		cfg_begin_n <= 1'h0;
		repeat (4) @(posedge aclk);
		cfg_begin_n <= 1'h1;
	endtask
	task automatic uclocks(input int n);
		repeat (n) begin
			@(posedge aclk);
			user_startup_clock <= 1'h1;
			repeat (2) @(posedge aclk);
			user_startup_clock <= 1'h0;
			repeat (2) @(posedge aclk);
		end
	endtask
endmodule
`default_nettype wire

/* src/cfg_handshake.sv */
// Configuration control and status handshake with AXI4-Lite registers.
// Assumes a data path that reports the last byte and frame errors,
// and pads that resolve the open-drain lines from the enables.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_loader_consts.svh"

//
// Contract
// - Status line driven low at power-up, released within 100 ms.
// - Any configuration error drives status low and halts until restart.
// - With auto-restart, status pulses low briefly then loading restarts alone.
// - Supply fault during user mode drives and holds status low.
// - Start input low keeps device in reset; configuring begins when high.
// - Start high begins active loading or readies passive acceptance at once.
// - Done line pulled low while configuration data is loading.
// - After final byte the done line is released to rise.
// - Rising done line commands initialization then user mode.
// - Done not high within ten clocks of last byte: error, status low.
// - Timeout-disable option suppresses that error; wait for rising edge.
// - Initialization lasts ten oscillator cycles, then user mode.
// - User clock option counts the ten cycles on the user clock.
module cfg_handshake
	import cfg_loader_pkg::*;
#(
	parameter logic [23:0] POWERUP_CYCLES = 24'(`CFG_POWERUP_CYC)
) (
	input  wire logic                       aclk,                   // System clock
	input  wire logic                       aresetn,                // Synchronous reset, low
	input  wire logic [7:0]                 s_axi_awaddr,           // Write address
	input  wire logic                       s_axi_awvalid,          // Write address valid
	output logic                            s_axi_awready,          // Write address ready
	input  wire logic [31:0]                s_axi_wdata,            // Write data
	input  wire logic [3:0]                 s_axi_wstrb,            // Write strobes
	input  wire logic                       s_axi_wvalid,           // Write data valid
	output logic                            s_axi_wready,           // Write data ready
	output logic [1:0]                      s_axi_bresp,            // Write response
	output logic                            s_axi_bvalid,           // Write response valid
	input  wire logic                       s_axi_bready,           // Write response ready
	input  wire logic [7:0]                 s_axi_araddr,           // Read address
	input  wire logic                       s_axi_arvalid,          // Read address valid
	output logic                            s_axi_arready,          // Read address ready
	output logic [31:0]                     s_axi_rdata,            // Read data
	output logic [1:0]                      s_axi_rresp,            // Read response
	output logic                            s_axi_rvalid,           // Read data valid
	input  wire logic                       s_axi_rready,           // Read data ready
	input  wire logic                       cfg_begin_n,            // Start input, low holds reset
	input  wire logic                       cfg_status_low_n_in,    // Sensed status line
	output logic                            cfg_status_low_n_oe,    // Pull status line low
	input  wire logic                       cfg_finished_wired_in,  // Sensed done line
	output logic                            cfg_finished_wired_oe,  // Pull done line low
	input  wire logic                       user_startup_clock,     // User start-up clock level
	output logic                            internal_osc_clock_out, // Oscillator clock out
	input  wire logic                       last_byte_read,         // Final data byte pulse
	input  wire logic                       frame_error,            // Data error pulse
	input  wire logic                       supply_fault,           // Supply fault level
	output logic                            load_enable,            // Data path may load
	output logic                            user_mode,              // Device in user mode
	output cfg_loader_pkg::cfg_state_t      cfg_phase,              // Current phase
	output logic                            irq                     // Interrupt, high
);
	import cfg_loader_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cfg_state_t  state;
	cfg_state_t  next_state;
	logic [3:0]  ctrl;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic [2:0]  next_irq_stat;
	logic [2:0]  irq_event;
	logic        power_fault;
	logic        done_prev;
	logic        done_rise;
	logic        user_prev;
	logic        user_rise;
	logic        osc_tick;
	logic        timer_reached;
	logic        tick_reached;
	logic        tick_step;
	logic [23:0] timer_limit;
	logic        phase_change;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_commit;
	logic        wr_hit;
	logic        auto_restart;
	logic        timeout_dis;
	logic        user_clk_sel;

	assign auto_restart = ctrl[`CFG_CTRL_AUTO_RESTART];
	assign timeout_dis  = ctrl[`CFG_CTRL_TIMEOUT_DIS];
	assign user_clk_sel = ctrl[`CFG_CTRL_USER_CLK];

	// ----------------------------------------------------------------
	// Oscillator and counters
	// ----------------------------------------------------------------
	rate_divider #(.DIV(`CFG_OSC_DIV)) osc_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (osc_tick)
	);

	assign phase_change = (next_state != state);
	assign timer_limit  = (state == CFG_POWERUP) ? POWERUP_CYCLES : 24'(`CFG_RESTART_CYC);

	span_counter #(.W(24)) phase_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (phase_change),
		.step    (1'b1),
		.limit   (timer_limit),
		.reached (timer_reached)
	);

	assign tick_step = (state == CFG_INIT && user_clk_sel) ? user_rise : osc_tick;

	span_counter #(.W(4)) tick_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (phase_change),
		.step    (tick_step),
		.limit   ((state == CFG_INIT) ? `CFG_INIT_TK : `CFG_DONE_TIMEOUT_TK),
		.reached (tick_reached)
	);

	// ----------------------------------------------------------------
	// Line sensing
	// ----------------------------------------------------------------
	// Done line rising edge
	assign done_rise = cfg_finished_wired_in && !done_prev;
	assign user_rise = user_startup_clock && !user_prev;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_prev <= 1'b1;
			user_prev <= 1'b0;
		end else begin
			done_prev <= cfg_finished_wired_in;
			user_prev <= user_startup_clock;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			internal_osc_clock_out <= 1'b0;
		end else if (osc_tick) begin
			internal_osc_clock_out <= !internal_osc_clock_out;
		end
	end

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			CFG_POWERUP:   if (timer_reached) next_state = CFG_IDLE;
			CFG_IDLE:      if (cfg_begin_n) next_state = CFG_LOAD;
			CFG_LOAD: begin
				if (frame_error) next_state = CFG_ERROR;
				else if (last_byte_read) next_state = CFG_DONE_WAIT;
			end
			CFG_DONE_WAIT: begin
				if (done_rise) next_state = CFG_INIT;
				else if (tick_reached && !timeout_dis) next_state = CFG_ERROR;
			end
			CFG_INIT:      if (tick_reached) next_state = CFG_USER;
			CFG_USER:      if (supply_fault) next_state = CFG_ERROR;
			CFG_ERROR:     if (auto_restart && !power_fault) next_state = CFG_RESTART;
			CFG_RESTART:   if (timer_reached) next_state = CFG_LOAD;
			default:       next_state = CFG_POWERUP;
		endcase
		if (!cfg_begin_n && state != CFG_POWERUP) begin
			next_state = CFG_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= CFG_POWERUP;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_fault <= 1'b0;
		end else if (state == CFG_USER && next_state == CFG_ERROR) begin
			power_fault <= 1'b1;
		end else if (next_state != CFG_ERROR) begin
			power_fault <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin and status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_status_low_n_oe   <= 1'b1;
			cfg_finished_wired_oe <= 1'b0;
			load_enable           <= 1'b0;
			user_mode             <= 1'b0;
			cfg_phase             <= CFG_POWERUP;
		end else begin
			cfg_status_low_n_oe   <= (next_state == CFG_POWERUP) || (next_state == CFG_ERROR) ||
			                         (next_state == CFG_RESTART);
			cfg_finished_wired_oe <= (next_state == CFG_LOAD);
			load_enable           <= (next_state == CFG_LOAD);
			user_mode             <= (next_state == CFG_USER);
			cfg_phase             <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_event[`CFG_IRQ_ERROR]  = (next_state == CFG_ERROR) && (state != CFG_ERROR);
	assign irq_event[`CFG_IRQ_USER]   = (next_state == CFG_USER) && (state != CFG_USER);
	assign irq_event[`CFG_IRQ_SUPPLY] = (state == CFG_USER) && (next_state == CFG_ERROR);

	always_comb begin
		next_irq_stat = irq_stat;
		if (wr_commit && wr_hit && aw_addr == `CFG_REG_IRQ_STAT && w_strb[0]) begin
			next_irq_stat = irq_stat & ~w_data[2:0];
		end
		// Set wins over clear
		next_irq_stat = next_irq_stat | irq_event;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= `CFG_IRQ_RESET;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write side
	// ----------------------------------------------------------------
	assign wr_commit = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit    = (aw_addr == `CFG_REG_CTRL) || (aw_addr == `CFG_REG_STATE) ||
	                   (aw_addr == `CFG_REG_IRQ_STAT) || (aw_addr == `CFG_REG_IRQ_MASK);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_held       <= 1'b0;
			aw_addr       <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
		end else if (wr_commit) begin
			aw_held       <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (wr_commit) begin
			w_held       <= 1'b0;
		end else if (!w_held && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CFG_RESP_OKAY;
		end else if (wr_commit) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `CFG_RESP_OKAY : `CFG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl     <= `CFG_CTRL_RESET;
			irq_mask <= `CFG_IRQ_RESET;
		end else if (wr_commit && w_strb[0]) begin
			if (aw_addr == `CFG_REG_CTRL) ctrl <= w_data[3:0];
			if (aw_addr == `CFG_REG_IRQ_MASK) irq_mask <= w_data[2:0];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read side
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CFG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `CFG_RESP_OKAY;
			case (s_axi_araddr)
				`CFG_REG_CTRL:     s_axi_rdata <= {28'h0000000, ctrl};
				`CFG_REG_STATE:    s_axi_rdata <= {24'h000000, cfg_status_low_n_in,
				                                   cfg_finished_wired_in, cfg_begin_n,
				                                   power_fault, 1'b0, state};
				`CFG_REG_IRQ_STAT: s_axi_rdata <= {29'h0000000, irq_stat};
				`CFG_REG_IRQ_MASK: s_axi_rdata <= {29'h0000000, irq_mask};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `CFG_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	powerup_drive_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_POWERUP) |-> cfg_status_low_n_oe && !load_enable)
		else $error("status line not driven during power-up");

	error_hold_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_ERROR && !auto_restart && cfg_begin_n) ##1 cfg_begin_n
		|-> (state == CFG_ERROR) && cfg_status_low_n_oe)
		else $error("error state not held with status low");

	restart_pulse_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		($rose(state == CFG_RESTART) && cfg_begin_n) ##1 cfg_begin_n[*7]
		|-> cfg_status_low_n_oe && (state == CFG_RESTART))
		else $error("auto restart pulse too short");

	supply_fault_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_USER && supply_fault && cfg_begin_n)
		|=> (state == CFG_ERROR) && cfg_status_low_n_oe && !user_mode)
		else $error("supply fault did not raise error");

	hold_reset_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(!cfg_begin_n && state != CFG_POWERUP) |=> (state == CFG_IDLE) && !cfg_finished_wired_oe)
		else $error("start low did not hold reset");

	start_load_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_IDLE && cfg_begin_n) |=> load_enable && cfg_finished_wired_oe)
		else $error("loading did not start at once");

	done_release_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_LOAD && last_byte_read && !frame_error && cfg_begin_n)
		|=> !cfg_finished_wired_oe && (state == CFG_DONE_WAIT))
		else $error("done line not released after last byte");

	init_trigger_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_DONE_WAIT && done_rise && cfg_begin_n) |=> (state == CFG_INIT))
		else $error("done rise did not start initialization");

	timeout_error_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_DONE_WAIT && !done_rise && tick_reached && !timeout_dis && cfg_begin_n)
		|=> cfg_status_low_n_oe && (state == CFG_ERROR))
		else $error("done timeout did not flag error");

	no_timeout_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state == CFG_DONE_WAIT && !done_rise && timeout_dis && cfg_begin_n)
		|=> (state == CFG_DONE_WAIT))
		else $error("timeout raised while disabled");
endmodule
`default_nettype wire

/* src/cfg_loader_consts.svh */
// Named constants for the configuration handshake block.
// Assumes a 100 MHz system clock and an AXI4-Lite register port.
`ifndef CFG_LOADER_CONSTS_SVH
`define CFG_LOADER_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFG_CLK_MHZ          100
`define CFG_POWERUP_MS       100
`define CFG_POWERUP_CYC      (`CFG_POWERUP_MS * 1000 * `CFG_CLK_MHZ)
`define CFG_RESTART_US       2
`define CFG_RESTART_CYC      (`CFG_RESTART_US * `CFG_CLK_MHZ)
`define CFG_OSC_KHZ          4000
`define CFG_OSC_DIV          ((`CFG_CLK_MHZ * 1000) / `CFG_OSC_KHZ)
`define CFG_DONE_TIMEOUT_TK  4'ha
`define CFG_INIT_TK          4'ha

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CFG_REG_CTRL         8'h00
`define CFG_REG_STATE        8'h04
`define CFG_REG_IRQ_STAT     8'h08
`define CFG_REG_IRQ_MASK     8'h0c

// ----------------------------------------------------------------
// Control fields, interrupt fields, bus answers
// ----------------------------------------------------------------
`define CFG_CTRL_AUTO_RESTART 0
`define CFG_CTRL_TIMEOUT_DIS  1
`define CFG_CTRL_USER_CLK     2
`define CFG_CTRL_ACTIVE       3
`define CFG_CTRL_RESET        4'h0
`define CFG_IRQ_ERROR         0
`define CFG_IRQ_USER          1
`define CFG_IRQ_SUPPLY        2
`define CFG_IRQ_RESET         3'h0
`define CFG_RESP_OKAY         2'h0
`define CFG_RESP_SLVERR       2'h2

`endif

/* src/cfg_loader_pkg.sv */
// Types shared by the configuration handshake block.
// Assumes nothing beyond the constants header.
package cfg_loader_pkg;

	// Gray along power-up, idle, load, done wait, init, user
	typedef enum logic [2:0] {
		CFG_POWERUP   = 3'h0,
		CFG_IDLE      = 3'h1,
		CFG_LOAD      = 3'h3,
		CFG_DONE_WAIT = 3'h2,
		CFG_INIT      = 3'h6,
		CFG_USER      = 3'h7,
		CFG_ERROR     = 3'h5,
		CFG_RESTART   = 3'h4
	} cfg_state_t;

endpackage

/* src/rate_divider.sv */
// One-cycle enable pulse every DIV system clocks.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
	parameter int DIV = 25
) (
	input  wire logic aclk,    // System clock
	input  wire logic aresetn, // Synchronous reset, low
	output logic      tick     // Enable pulse
);
	logic [7:0] count;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 8'h00;
			tick  <= 1'b0;
		end else if (count == 8'(DIV - 1)) begin
			count <= 8'h00;
			tick  <= 1'b1;
		end else begin
			count <= 8'(count + 8'h01);
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* src/span_counter.sv */
// Saturating event counter with a reached flag.
// Assumes clear and step come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module span_counter #(
	parameter int W = 24
) (
	input  wire logic         aclk,    // System clock
	input  wire logic         aresetn, // Synchronous reset, low
	input  wire logic         clear,   // Restart from zero
	input  wire logic         step,    // Count one event
	input  wire logic [W-1:0] limit,   // Target count
	output logic              reached  // Count at or past target
);
	logic [W-1:0] count;

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			count <= '0;
		end else if (step && !reached) begin
			count <= W'(count + 1'b1);
		end
	end

	assign reached = (count >= limit);
endmodule
`default_nettype wire
